// ### backup_domain_clock_control.sv
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
`include "bdc_regs.svh"

module backup_domain_clock_control (
  input  wire logic                     core_clk,
  input  wire logic                     arst_n,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [`BDC_ADDR_W-1:0]   paddr,
  input  wire logic [31:0]              pwdata,
  input  wire logic [3:0]               pstrb,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire logic                     backupWriteEnable,
  input  wire logic                     slowExtStablePin,
  input  wire logic                     slowExtTick,
  input  wire logic                     slowIntTick,
  input  wire logic                     fastExtTick,
  output logic                          slowExtOscEnable,
  output logic                          slowExtBypassSelect,
  output logic      [1:0]               slowExtDriveStrength,
  output logic                          calendarTick,
  output logic                          backupDomainSoftReset,
  output logic                          irq
);

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  bdc_pkg::bus_state_t busSt_r;
  bdc_pkg::bus_state_t busSt_nxt;
  logic [1:0]  waitCnt_r;
  logic [1:0]  waitCnt_nxt;
  logic        pready_r;
  logic        pslverr_r;
  logic [31:0] prdata_r;

  wire setupPh = psel & ~penable;
  wire accessPh = psel & penable;
  wire done = accessPh & pready_r;
  wire selCtrl = (paddr[7:2] == 6'(`BDC_CTRL_OFF >> 2));
  wire selStat = (paddr[7:2] == 6'(`BDC_STAT_OFF >> 2));
  wire selMask = (paddr[7:2] == 6'(`BDC_MASK_OFF >> 2));
  wire mapped = selCtrl | selStat | selMask;
  wire wrDone = done & pwrite & mapped;
  wire wrCtrl = wrDone & selCtrl;
  wire wrStat = wrDone & selStat;
  wire wrMask = wrDone & selMask;

  // byte lanes turn into a per-bit write mask
  logic [31:0] laneMask;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_lane
      assign laneMask[8*gi +: 8] = {8{pstrb[gi]}}; // RQ13
    end
  endgenerate
  wire [31:0] wBits = pwdata & laneMask;

  // ----------------------------------------
  // control fields
  // ----------------------------------------
  logic       oscEn_r;
  logic       bypass_r;
  logic [1:0] drive_r;
  logic [1:0] srcSel_r;
  logic       gate_r;
  logic       softRst_r;
  logic       ready_r;

  wire allowProt = backupWriteEnable; // RQ2
  wire srcFree = (srcSel_r == `BDC_SEL_RST);
  wire lane0 = pstrb[0];
  wire lane1 = pstrb[1];
  wire lane2 = pstrb[2];

  wire wrEn = wrCtrl & lane0 & allowProt & ~softRst_r;
  wire wrByp = wrCtrl & lane0 & allowProt & ~softRst_r;
  wire wrDrv = wrCtrl & lane0 & ~softRst_r;
  wire wrGate = wrCtrl & lane1 & allowProt & ~softRst_r;
  // source only changes from the unconfigured state
  wire wrSrc = wrCtrl & lane1 & allowProt & ~softRst_r & srcFree; // RQ9
  wire wrSrst = wrCtrl & lane2;

  wire [1:0] newSrc = wBits[`BDC_SEL_HI:`BDC_SEL_LO];
  wire protTouched = lane0 | lane1;
  wire srcRefused = wrCtrl & lane1 & ~srcFree & (newSrc != srcSel_r);
  wire refused = (wrCtrl & protTouched & ~allowProt) | srcRefused;

  // arst_n is the backup-domain reset; system reset is not wired here
  always_ff @(posedge core_clk or negedge arst_n) begin // RQ1
    if (!arst_n) begin
      softRst_r <= 1'b0;
    end else if (wrSrst) begin
      softRst_r <= wBits[`BDC_SRST_BIT]; // RQ11
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      oscEn_r  <= 1'b0;
      bypass_r <= 1'b0;
      drive_r  <= `BDC_DRV_RST;
      srcSel_r <= `BDC_SEL_RST;
      gate_r   <= 1'b0;
    end else if (softRst_r) begin // RQ11 RQ12
      oscEn_r  <= 1'b0;
      bypass_r <= 1'b0;
      drive_r  <= `BDC_DRV_RST; // RQ7
      srcSel_r <= `BDC_SEL_RST;
      gate_r   <= 1'b0;
    end else begin
      if (wrEn) begin
        oscEn_r <= wBits[`BDC_EN_BIT]; // RQ3
      end
      if (wrByp) begin
        bypass_r <= wBits[`BDC_BYP_BIT]; // RQ5
      end
      if (wrDrv) begin
        drive_r <= wBits[`BDC_DRV_HI:`BDC_DRV_LO]; // RQ6
      end
      if (wrSrc) begin
        srcSel_r <= newSrc; // RQ8
      end
      if (wrGate) begin
        gate_r <= wBits[`BDC_GATE_BIT]; // RQ10
      end
    end
  end

  // ----------------------------------------
  // oscillator ready
  // ----------------------------------------
  // stable pin is analog-side, so three stages, and the filter follows only when stages 2 and 3 agree
  logic stableS1_r;
  logic stableS2_r;
  logic stableS3_r;
  logic stableFilt_r;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      stableS1_r <= 1'b0;
      stableS2_r <= 1'b0;
      stableS3_r <= 1'b0;
    end else begin
      stableS1_r <= slowExtStablePin;
      stableS2_r <= stableS1_r;
      stableS3_r <= stableS2_r;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      stableFilt_r <= 1'b0;
    end else if (stableS2_r == stableS3_r) begin
      stableFilt_r <= stableS3_r;
    end
  end

  // a disabled or resetting oscillator never reports ready
  wire ready_nxt = stableFilt_r & oscEn_r & ~softRst_r;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ready_r <= 1'b0;
    end else begin
      ready_r <= ready_nxt; // RQ4
    end
  end

  // ----------------------------------------
  // calendar clock enable
  // ----------------------------------------
  logic calTick_r;
  logic tickSel;

  always_comb begin
    unique case (bdc_pkg::rtc_src_t'(srcSel_r))
      bdc_pkg::SRC_NONE:     tickSel = 1'b0;
      bdc_pkg::SRC_SLOW_EXT: tickSel = slowExtTick;
      bdc_pkg::SRC_SLOW_INT: tickSel = slowIntTick;
      bdc_pkg::SRC_FAST_EXT: tickSel = fastExtTick;
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      calTick_r <= 1'b0;
    end else begin
      calTick_r <= tickSel & gate_r & ~softRst_r; // RQ10 RQ8
    end
  end

  // ----------------------------------------
  // events and interrupt
  // ----------------------------------------
  logic [`BDC_EVT_W-1:0] status_r;
  logic [`BDC_EVT_W-1:0] mask_r;
  logic                  irq_r;
  logic [`BDC_EVT_W-1:0] evt;

  always_comb begin
    evt = '0;
    evt[`BDC_EVT_RISE]   = ready_nxt & ~ready_r;
    evt[`BDC_EVT_FALL]   = ~ready_nxt & ready_r;
    evt[`BDC_EVT_REFUSE] = refused;
  end

  wire [`BDC_EVT_W-1:0] clrBits = wrStat & lane0 ? wBits[`BDC_EVT_W-1:0] : '0;
  // set beats clear in the same cycle
  wire [`BDC_EVT_W-1:0] status_nxt = (status_r & ~clrBits) | evt;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      status_r <= '0;
      mask_r   <= '0;
      irq_r    <= 1'b0;
    end else begin
      status_r <= status_nxt;
      if (wrMask & lane0) begin
        mask_r <= wBits[`BDC_EVT_W-1:0];
      end
      irq_r <= |(status_nxt & mask_r);
    end
  end

  // ----------------------------------------
  // read data
  // ----------------------------------------
  logic [31:0] ctrlView;

  always_comb begin
    ctrlView = '0;
    ctrlView[`BDC_EN_BIT] = oscEn_r;
    ctrlView[`BDC_RDY_BIT] = ready_r;
    ctrlView[`BDC_BYP_BIT] = bypass_r;
    ctrlView[`BDC_DRV_HI:`BDC_DRV_LO] = drive_r;
    ctrlView[`BDC_SEL_HI:`BDC_SEL_LO] = srcSel_r;
    ctrlView[`BDC_GATE_BIT] = gate_r;
    ctrlView[`BDC_SRST_BIT] = softRst_r;
  end

  wire [31:0] rdMux = selCtrl ? ctrlView :
                      selStat ? {29'h0, status_r} :
                      selMask ? {29'h0, mask_r} : 32'h0;

  // ----------------------------------------
  // bus sequencer
  // ----------------------------------------
  // a setup right after a completion costs extra waits
  wire [1:0] waitsIdle = `BDC_BASE_WAITS; // RQ13
  wire [1:0] waitsBack = `BDC_BACK_WAITS; // RQ14
  wire [1:0] waitsLoad = (busSt_r == bdc_pkg::BUS_LAST) ? waitsBack : waitsIdle;
  wire goResp = (busSt_nxt == bdc_pkg::BUS_RESP) && (busSt_r != bdc_pkg::BUS_RESP);

  always_comb begin
    busSt_nxt = busSt_r;
    waitCnt_nxt = waitCnt_r;
    unique case (busSt_r)
      bdc_pkg::BUS_IDLE, bdc_pkg::BUS_LAST: begin
        busSt_nxt = bdc_pkg::BUS_IDLE;
        if (setupPh) begin
          waitCnt_nxt = waitsLoad;
          busSt_nxt = (waitsLoad == 2'h0) ? bdc_pkg::BUS_RESP : bdc_pkg::BUS_WAIT;
        end
      end
      bdc_pkg::BUS_WAIT: begin
        if (accessPh) begin
          waitCnt_nxt = waitCnt_r - 2'h1;
          if (waitCnt_r == 2'h1) begin
            busSt_nxt = bdc_pkg::BUS_RESP;
          end
        end
      end
      bdc_pkg::BUS_RESP: begin
        if (done) begin
          busSt_nxt = bdc_pkg::BUS_LAST;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      busSt_r   <= bdc_pkg::BUS_IDLE;
      waitCnt_r <= 2'h0;
    end else begin
      busSt_r   <= busSt_nxt;
      waitCnt_r <= waitCnt_nxt;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0;
    end else begin
      pready_r <= (busSt_nxt == bdc_pkg::BUS_RESP);
      if (goResp) begin
        pslverr_r <= ~mapped;
        prdata_r  <= pwrite ? 32'h0 : rdMux;
      end else if (done) begin
        pslverr_r <= 1'b0;
        prdata_r  <= 32'h0;
      end
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign slowExtOscEnable = oscEn_r; // RQ3
  assign slowExtBypassSelect = bypass_r; // RQ5
  assign slowExtDriveStrength = drive_r; // RQ6
  assign calendarTick = calTick_r;
  assign backupDomainSoftReset = softRst_r; // RQ11
  assign irq = irq_r;

endmodule // backup_domain_clock_control

// ### bdc_regs.svh
`ifndef BDC_REGS_SVH
`define BDC_REGS_SVH
// Operation
// RQ1: register resets only on backup-domain reset
// RQ2: protected fields need backup write enable; the code writes drive strength (bits 4:3) without it
// RQ3: bit 0 turns slow oscillator on
// RQ4: bit 1 shows slow clock stable
// RQ5: bit 2 selects bypass external clock
// RQ6: bits 4:3 set oscillator drive strength
// RQ7: drive strength returns to default on reset
// RQ8: bits 9:8 select calendar clock source
// RQ9: source change needs backup reset first
// RQ10: bit 15 gates calendar clock
// RQ11: bit 16 holds backup domain in reset
// RQ12: soft reset touches oscillator, calendar, register
// RQ13: byte, half and word access, 0-3 waits
// RQ14: back-to-back access inserts wait states

// ----------------------------------------
// register map
// ----------------------------------------
`define BDC_ADDR_W      8
`define BDC_CTRL_OFF    8'h20
`define BDC_STAT_OFF    8'h40
`define BDC_MASK_OFF    8'h44
`define BDC_CTRL_RST    32'h00000018

// ----------------------------------------
// control field positions
// ----------------------------------------
`define BDC_EN_BIT      0
`define BDC_RDY_BIT     1
`define BDC_BYP_BIT     2
`define BDC_DRV_LO      3
`define BDC_DRV_HI      4
`define BDC_SEL_LO      8
`define BDC_SEL_HI      9
`define BDC_GATE_BIT    15
`define BDC_SRST_BIT    16
`define BDC_DRV_RST     2'h3
`define BDC_SEL_RST     2'h0

// ----------------------------------------
// events and bus timing
// ----------------------------------------
`define BDC_EVT_W       3
`define BDC_EVT_RISE    0
`define BDC_EVT_FALL    1
`define BDC_EVT_REFUSE  2
`define BDC_BASE_WAITS  2'h0
`define BDC_BACK_WAITS  2'h2
`endif

// ### bdc_pkg.sv
package bdc_pkg;
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_WAIT = 2'b01,
    BUS_RESP = 2'b11,
    BUS_LAST = 2'b10
  } bus_state_t;

  typedef enum logic [1:0] {
    SRC_NONE     = 2'b00,
    SRC_SLOW_EXT = 2'b01,
    SRC_SLOW_INT = 2'b10,
    SRC_FAST_EXT = 2'b11
  } rtc_src_t;
endpackage

// ### bdc_monitor.sv
`timescale 1ns/1ps
`include "bdc_regs.svh"
module bdc_monitor (
  input wire logic                   core_clk,
  input wire logic                   arst_n,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [`BDC_ADDR_W-1:0] paddr,
  input wire logic [31:0]            pwdata,
  input wire logic [3:0]             pstrb,
  input wire logic [31:0]            prdata,
  input wire logic                   pready,
  input wire logic                   pslverr,
  input wire logic                   backupWriteEnable,
  input wire logic                   slowExtStablePin,
  input wire logic                   slowExtTick,
  input wire logic                   slowIntTick,
  input wire logic                   fastExtTick,
  input wire logic                   slowExtOscEnable,
  input wire logic                   slowExtBypassSelect,
  input wire logic [1:0]             slowExtDriveStrength,
  input wire logic                   calendarTick,
  input wire logic                   backupDomainSoftReset,
  input wire logic                   irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  wire setup = psel && !penable;
  wire ctrlAcc = psel && penable && pready && pwrite && {paddr[7:2], 2'b00} == `BDC_CTRL_OFF;
  // soft reset overrides field writes, so leave those cycles out
  wire ctrlWr = ctrlAcc && !pwdata[16] && !backupDomainSoftReset;
  sequence s_two_waits;
    !pready ##1 !pready ##1 pready;
  endsequence
  property p_ready_in_access; pready |-> psel && penable; endproperty
  a_ready_in_access: assert property (p_ready_in_access) else $error("ready outside access");
  property p_no_wait; setup && !$past(pready) |=> pready; endproperty
  a_no_wait: assert property (p_no_wait) else $error("idle access waited");
  property p_back_waits; setup && $past(pready) |=> s_two_waits; endproperty
  a_back_waits: assert property (p_back_waits) else $error("back to back waits wrong");
  property p_locked; ctrlWr && !backupWriteEnable |=> $stable(slowExtOscEnable) && $stable(slowExtBypassSelect);
  endproperty
  a_locked: assert property (p_locked) else $error("locked field changed");
  property p_enable; ctrlWr && backupWriteEnable && pstrb[0] |=>
    slowExtOscEnable == $past(pwdata[0]) && slowExtBypassSelect == $past(pwdata[2]); endproperty
  a_enable: assert property (p_enable) else $error("enable or bypass wrong");
  property p_drive; ctrlWr && pstrb[0] |=> slowExtDriveStrength == $past(pwdata[4:3]); endproperty
  a_drive: assert property (p_drive) else $error("drive strength wrong");
  property p_srst; ctrlAcc && pstrb[2] |=> backupDomainSoftReset == $past(pwdata[16]); endproperty
  a_srst: assert property (p_srst) else $error("soft reset bit wrong");
  property p_hold; backupDomainSoftReset && $past(backupDomainSoftReset) |->
    slowExtDriveStrength == 2'h3 && !slowExtOscEnable && !slowExtBypassSelect && !calendarTick; endproperty
  a_hold: assert property (p_hold) else $error("soft reset not held");
  property p_tick; calendarTick |-> $past(slowExtTick || slowIntTick || fastExtTick); endproperty
  a_tick: assert property (p_tick) else $error("tick without source");
endmodule // bdc_monitor
bind backup_domain_clock_control bdc_monitor bdc_monitor_inst (.core_clk(core_clk), .arst_n(arst_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .backupWriteEnable(backupWriteEnable),
  .slowExtStablePin(slowExtStablePin), .slowExtTick(slowExtTick), .slowIntTick(slowIntTick),
  .fastExtTick(fastExtTick), .slowExtOscEnable(slowExtOscEnable), .slowExtBypassSelect(slowExtBypassSelect),
  .slowExtDriveStrength(slowExtDriveStrength), .calendarTick(calendarTick),
  .backupDomainSoftReset(backupDomainSoftReset), .irq(irq));

// ### slow_crystal_model.sv
`timescale 1ns/1ps
module slow_crystal_model #(
  parameter int STARTUP = 12
) (
  input  wire logic core_clk,
  input  wire logic oscEnable,
  input  wire logic bypass,
  output logic      stablePin,
  output logic      tick
);
  int age = 0;
  initial begin
    stablePin = 1'b0;
    tick = 1'b0;
  end
  // crystal settles slowly; an external source in bypass is usable at once
  always @(posedge core_clk) begin
    age <= oscEnable ? age + 1 : 0;
    stablePin <= oscEnable && (bypass || age >= STARTUP);
    tick <= stablePin && age[1:0] == 2'h0;
  end
endmodule // slow_crystal_model

// ### tb_backup_domain_clock_control.sv
`timescale 1ns/1ps
`include "bdc_regs.svh"
module tb_backup_domain_clock_control;
  logic        clk, rstN, psel, penable, pwrite, pready, err, wen, stable, eTick, iTick, fTick;
  logic        oscEn, byp, calTick, srst, irq, slvErr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic [1:0]  drv;
  logic [1:0]  src [3] = '{2'h0, 2'h2, 2'h3};
  int          num_errors, checks, nCal, tcnt, n0, nAcc;
  backup_domain_clock_control backup_domain_clock_control_inst (.core_clk(clk), .arst_n(rstN), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(slvErr), .backupWriteEnable(wen), .slowExtStablePin(stable), .slowExtTick(eTick),
    .slowIntTick(iTick), .fastExtTick(fTick), .slowExtOscEnable(oscEn), .slowExtBypassSelect(byp),
    .slowExtDriveStrength(drv), .calendarTick(calTick), .backupDomainSoftReset(srst), .irq(irq));
  slow_crystal_model slow_crystal_model_inst (.core_clk(clk), .oscEnable(oscEn), .bypass(byp),
    .stablePin(stable), .tick(eTick));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    tcnt <= tcnt + 1;
    iTick <= tcnt[1:0] == 2'h0;
    fTick <= tcnt[0];
    nCal <= nCal + int'(calTick === 1'b1);
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // request stays up until pready; release is left to idle so back-to-back is possible
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    nAcc = 0;
    do begin
      @(posedge clk);
      nAcc++;
    end while (pready !== 1'b1);
    rd = prdata;
    err = slvErr;
  endtask
  task automatic idle;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
    apb(1'b1, a, d, s);
    idle();
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, 4'h0);
    idle();
    chk(rd, e);
  endtask
  task automatic outs(input logic [5:0] e);
    @(negedge clk);
    chk({26'h0, oscEn, byp, drv, srst, irq}, {26'h0, e});
    @(posedge clk);
  endtask
  task automatic ticks(input logic e);
    // a tick launched before the last write still lands at this edge
    @(negedge clk);
    n0 = nCal;
    repeat (40) @(posedge clk);
    chk(32'(nCal != n0), 32'(e));
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_reset;
    rstN <= 1'b0;
    repeat (2) @(posedge clk);
    rstN <= 1'b1;
    @(posedge clk);
    rdc(`BDC_CTRL_OFF, `BDC_CTRL_RST);
    outs(6'b001100);
  endtask
  task automatic t_bus;
    wen <= 1'b1;
    apb(1'b1, 8'h80, 32'hffff_ffff, 4'hf);
    chk({31'h0, err}, 32'h1);
    chk(nAcc, 32'(`BDC_BASE_WAITS) + 32'h1);
    apb(1'b1, `BDC_CTRL_OFF, 32'h0000_0008, 4'h3);
    apb(1'b0, `BDC_CTRL_OFF, 32'h0, 4'h0);
    idle();
    chk(rd, 32'h0000_0008);
    chk(nAcc, 32'(`BDC_BACK_WAITS) + 32'h1);
  endtask
  task automatic t_protect;
    wen <= 1'b0;
    wr(`BDC_CTRL_OFF, 32'h0000_8305);
    rdc(`BDC_CTRL_OFF, 32'h0);
    outs(6'b000000);
    rdc(`BDC_STAT_OFF, 32'h4);
    wr(`BDC_MASK_OFF, 32'h4);
    rdc(`BDC_MASK_OFF, 32'h4);
    outs(6'b000001);
    wr(`BDC_STAT_OFF, 32'h7);
    outs(6'b000000);
  endtask
  task automatic t_enable;
    wen <= 1'b1;
    wr(`BDC_CTRL_OFF, 32'h0000_8105);
    for (int i = 0; i < 20 && rd[1] !== 1'b1; i++) begin
      apb(1'b0, `BDC_CTRL_OFF, 32'h0, 4'h0);
      idle();
    end
    rdc(`BDC_CTRL_OFF, 32'h0000_8107);
    outs(6'b110000);
    ticks(1'b1);
    wr(`BDC_CTRL_OFF, 32'h0000_8205);
    rdc(`BDC_CTRL_OFF, 32'h0000_8107);
    outs(6'b110001);
    wr(`BDC_STAT_OFF, 32'h7);
    outs(6'b110000);
    wr(`BDC_CTRL_OFF, 32'h0000_0100, 4'h2);
    ticks(1'b0);
    wr(`BDC_CTRL_OFF, 32'h0, 4'h1);
    outs(6'b000000);
  endtask
  task automatic t_softrst;
    wr(`BDC_CTRL_OFF, 32'h0001_0000, 4'h4);
    rdc(`BDC_CTRL_OFF, 32'h0001_0018);
    outs(6'b001110);
    wr(`BDC_CTRL_OFF, 32'h0001_8305);
    rdc(`BDC_CTRL_OFF, 32'h0001_0018);
  endtask
  task automatic t_source;
    foreach (src[k]) begin
      wr(`BDC_CTRL_OFF, 32'h0001_0000, 4'h4);
      wr(`BDC_CTRL_OFF, 32'h0, 4'h4);
      wr(`BDC_CTRL_OFF, {16'h0, 1'b1, 5'h0, src[k], 8'h08});
      rdc(`BDC_CTRL_OFF, {16'h0, 1'b1, 5'h0, src[k], 8'h08});
      ticks(src[k] != 2'h0);
    end
  endtask
  task automatic finish_test;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    finish_test();
  end
  initial begin
    {rstN, psel, penable, pwrite, wen, iTick, fTick} = '0;
    paddr = '0;
    pwdata = '0;
    pstrb = '0;
    {tcnt, nCal, num_errors, checks} = '0;
    repeat (6) @(posedge clk);
    t_reset();
    t_bus();
    t_protect();
    t_enable();
    t_softrst();
    t_source();
    t_reset();
    finish_test();
  end
endmodule // tb_backup_domain_clock_control
